//--- sms_pkg.sv
// shared constants, register map and types of the serial port
package sms_pkg;

    // register bus
    localparam int AXI_ADDR_W = 4;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register offsets
    localparam logic [AXI_ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] DATA_OFS = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] STAT_OFS = 4'h8;
    localparam logic [AXI_ADDR_W-1:0] MASK_OFS = 4'hc;

    // control register fields
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_SEL_HIGH_BIT = 1;
    localparam int CTRL_MODF_EN_BIT = 2;
    localparam int CTRL_DIV_LSB = 8;
    localparam int DIV_W = 8;

    // control reset values
    localparam logic CTRL_MASTER_RST = 1'b0;
    localparam logic CTRL_SEL_HIGH_RST = 1'b0;
    localparam logic CTRL_MODF_EN_RST = 1'b0;
    localparam logic [DIV_W-1:0] CTRL_DIV_RST = 8'h02;

    // status register fields; the low EVT_W bits are sticky events
    localparam int EVT_W = 3;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_COLL_BIT = 1;
    localparam int ST_MODF_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_SEL_BIT = 4;
    localparam logic [EVT_W-1:0] STAT_RST = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

    // pin synchroniser
    localparam int SYNC_W = 4;
    localparam int SYNC_SCK = 0;
    localparam int SYNC_SEL = 1;
    localparam int SYNC_SDI = 2;
    localparam int SYNC_MSI = 3;

    typedef enum logic [2:0] {
        SMS_M_IDLE = 3'b001,
        SMS_M_LOW = 3'b010,
        SMS_M_HIGH = 3'b100
    } sms_mst_e;

endpackage

//--- sms_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sms_sync #(
    parameter int W = 1
) (
    input wire logic mclk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic [W-1:0] async_in, // pins from outside the clock domain
    output logic [W-1:0] sync_out // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sms_sync_s;

    sms_sync_s q;
    sms_sync_s d;

    always_comb begin
        d.meta = async_in;
        d.stable = q.meta;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.stable;
endmodule

//--- sms_axil.sv
// AXI4-Lite slave front end: turns bus transfers into register strobes
`timescale 1ns/1ps
module sms_axil (
    input wire logic mclk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [sms_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [sms_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
    input wire logic [sms_pkg::AXI_STRB_W-1:0] s_axi_wstrb, // byte enables
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [sms_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [sms_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic wr_en, // one-cycle register write strobe
    output logic [sms_pkg::AXI_ADDR_W-1:0] wr_addr, // register write address
    output logic [sms_pkg::AXI_DATA_W-1:0] wr_data, // register write data
    output logic [sms_pkg::AXI_STRB_W-1:0] wr_strb, // register byte enables
    input wire logic wr_ok, // write address is mapped
    output logic rd_en, // one-cycle register read strobe
    output logic [sms_pkg::AXI_ADDR_W-1:0] rd_addr, // register read address
    input wire logic [sms_pkg::AXI_DATA_W-1:0] rd_data, // read value
    input wire logic rd_ok // read address is mapped
);
    import sms_pkg::*;

    typedef struct packed {
        logic aw_full;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic w_full;
        logic [AXI_DATA_W-1:0] wdata;
        logic [AXI_STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } sms_axil_s;

    sms_axil_s q;
    sms_axil_s d;

    assign s_axi_awready = ~q.aw_full & ~q.bvalid;
    assign s_axi_wready = ~q.w_full & ~q.bvalid;
    assign s_axi_arready = ~q.rvalid;
    assign wr_en = q.aw_full & q.w_full & ~q.bvalid;
    assign wr_addr = q.awaddr;
    assign wr_data = q.wdata;
    assign wr_strb = q.wstrb;
    assign rd_en = s_axi_arvalid & ~q.rvalid;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        d = q;
        // address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_full = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (wr_en) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (rd_en) begin
            d.rvalid = 1'b1;
            d.rdata = rd_data;
            d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
endmodule

//--- sms_spi_port.sv
// serial peripheral port, master or slave, with AXI4-Lite registers
`timescale 1ns/1ps
module sms_spi_port #(
    parameter int DATA_W = 8
) (
    input wire logic mclk, // system clock, 200 MHz
    input wire logic reset, // async reset, active high
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [sms_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write addr
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [sms_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
    input wire logic [sms_pkg::AXI_STRB_W-1:0] s_axi_wstrb, // byte enables
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [sms_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read addr
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [sms_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic irq, // level interrupt, active high
    output logic master_serial_clock_out, // serial clock as master
    output logic master_serial_out, // master data out
    output logic master_out_en, // master clock and data drive enable
    input wire logic master_serial_in, // master data in
    input wire logic slave_serial_clock_in, // serial clock as slave
    input wire logic slave_serial_in, // slave data in
    output logic slave_serial_out, // slave data out
    output logic slave_serial_out_en, // slave data out drive enable
    output logic slave_serial_out_pullup, // weak pullup on slave data pin
    input wire logic slave_select_in // slave select, level configurable
);
    import sms_pkg::*;

    localparam int BW = $clog2(DATA_W);
    localparam logic [BW-1:0] LAST_BIT = BW'(DATA_W - 1);

    typedef struct packed {
        logic master;
        logic sel_high;
        logic modf_en;
        logic [DIV_W-1:0] div;
        logic [EVT_W-1:0] stat;
        logic [EVT_W-1:0] mask;
        sms_mst_e mst;
        logic [DIV_W-1:0] cnt;
        logic [BW-1:0] bits;
        logic [DATA_W-1:0] sh;
        logic [DATA_W-1:0] rx;
        logic sclk;
        logic sck_prev;
    } sms_port_s;

    sms_port_s q;
    sms_port_s d;

    logic [SYNC_W-1:0] pins_s;
    logic sck_s;
    logic sel_s;
    logic sdi_s;
    logic msi_s;
    logic sel_act;
    logic wr_en;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [AXI_DATA_W-1:0] wr_data;
    logic [AXI_STRB_W-1:0] wr_strb;
    logic rd_en;
    logic [AXI_ADDR_W-1:0] rd_addr;
    logic [AXI_DATA_W-1:0] rd_data;

    // true for the four mapped word offsets
    function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] a);
        reg_hit = (a == CTRL_OFS) || (a == DATA_OFS) ||
                  (a == STAT_OFS) || (a == MASK_OFS);
    endfunction

    // shift one bit in at the bottom, msb leaves first
    function automatic logic [DATA_W-1:0] shift_in(
        input logic [DATA_W-1:0] v,
        input logic b
    );
        shift_in = {v[DATA_W-2:0], b};
    endfunction

    sms_sync #(
        .W(SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in({master_serial_in, slave_serial_in, ~slave_select_in,
                   slave_serial_clock_in}),
        .sync_out(pins_s)
    );

    assign sck_s = pins_s[SYNC_SCK];
    assign sel_s = ~pins_s[SYNC_SEL]; // held inverted: reset reads idle
    assign sdi_s = pins_s[SYNC_SDI];
    assign msi_s = pins_s[SYNC_MSI];

    sms_axil u_axil (
        .mclk(mclk),
        .reset(reset),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(reg_hit(wr_addr)),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(reg_hit(rd_addr))
    );

    // select pin at its configured active level
    assign sel_act = (sel_s == q.sel_high);

    // read mux; DATA returns the receive buffer
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            CTRL_OFS: begin
                rd_data[CTRL_MASTER_BIT] = q.master;
                rd_data[CTRL_SEL_HIGH_BIT] = q.sel_high;
                rd_data[CTRL_MODF_EN_BIT] = q.modf_en;
                rd_data[CTRL_DIV_LSB +: DIV_W] = q.div;
            end
            DATA_OFS: rd_data[DATA_W-1:0] = q.rx;
            STAT_OFS: begin
                rd_data[EVT_W-1:0] = q.stat;
                rd_data[ST_BUSY_BIT] = (q.mst != SMS_M_IDLE);
                // in master mode the select pin reads as a plain input
                rd_data[ST_SEL_BIT] = sel_s;
            end
            MASK_OFS: rd_data[EVT_W-1:0] = q.mask;
            default: rd_data = '0;
        endcase
    end

    always_comb begin
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] clr;
        logic [DATA_W-1:0] shv;
        evt = '0;
        clr = '0;
        shv = '0;
        d = q;
        d.sck_prev = sck_s;

        // master sequencer: each half period lasts div+1 clocks, at least 1
        case (q.mst)
            SMS_M_IDLE: begin
                d.sclk = 1'b0;
            end
            SMS_M_LOW: begin
                if (q.cnt == '0) begin
                    d.sclk = 1'b1;
                    d.cnt = q.div;
                    d.mst = SMS_M_HIGH;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            SMS_M_HIGH: begin
                if (q.cnt == '0) begin
                    // sample at the end of the high phase, shift in at lsb
                    shv = shift_in(q.sh, msi_s);
                    d.sh = shv;
                    d.sclk = 1'b0;
                    d.cnt = q.div;
                    d.bits = q.bits + 1'b1;
                    if (q.bits == LAST_BIT) begin
                        d.rx = shv;
                        evt[ST_DONE_BIT] = 1'b1;
                        d.bits = '0;
                        d.mst = SMS_M_IDLE;
                    end else begin
                        d.mst = SMS_M_LOW;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                d.mst = SMS_M_IDLE;
                d.sclk = 1'b0;
            end
        endcase

        // slave shifter, one bit per synchronised rising clock edge
        if (!q.master) begin
            if (!sel_act) begin
                d.bits = '0;
            end else if (sck_s && !q.sck_prev) begin
                // relies on edges at least four clocks apart; nothing here enforces it
                shv = shift_in(q.sh, sdi_s);
                d.sh = shv;
                d.bits = q.bits + 1'b1;
                if (q.bits == LAST_BIT) begin
                    d.rx = shv;
                    evt[ST_DONE_BIT] = 1'b1;
                    d.bits = '0;
                end
            end
        end

        // register writes
        if (wr_en) begin
            case (wr_addr)
                CTRL_OFS: begin
                    if (wr_strb[0]) begin
                        d.master = wr_data[CTRL_MASTER_BIT];
                        d.sel_high = wr_data[CTRL_SEL_HIGH_BIT];
                        d.modf_en = wr_data[CTRL_MODF_EN_BIT];
                    end
                    if (wr_strb[1]) begin
                        d.div = wr_data[CTRL_DIV_LSB +: DIV_W];
                    end
                end
                DATA_OFS: begin
                    if (wr_strb[0] && q.master) begin
                        // busy, or another master holds the select line
                        if (q.mst != SMS_M_IDLE || (q.modf_en && sel_act)) begin
                            evt[ST_COLL_BIT] = 1'b1;
                        end else begin
                            d.sh = wr_data[DATA_W-1:0];
                            d.bits = '0;
                            d.cnt = q.div;
                            d.mst = SMS_M_LOW;
                        end
                    end else if (wr_strb[0]) begin
                        // slave only preloads; the far master starts
                        if (sel_act && q.bits != '0) begin
                            evt[ST_COLL_BIT] = 1'b1;
                        end else begin
                            d.sh = wr_data[DATA_W-1:0];
                        end
                    end
                end
                STAT_OFS: begin
                    if (wr_strb[0]) begin
                        clr = wr_data[EVT_W-1:0];
                    end
                end
                MASK_OFS: begin
                    if (wr_strb[0]) begin
                        d.mask = wr_data[EVT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // mode fault: select driven active while we are master
        if (q.master && q.modf_en && sel_act) begin
            evt[ST_MODF_BIT] = 1'b1;
            d.mst = SMS_M_IDLE;
            d.sclk = 1'b0;
            d.bits = '0;
        end
        // leaving master mode drops any transfer under way
        if (!d.master && q.mst != SMS_M_IDLE) begin
            d.mst = SMS_M_IDLE;
            d.sclk = 1'b0;
        end

        // a new event beats a clear in the same cycle
        d.stat = (q.stat & ~clr) | evt;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.master <= CTRL_MASTER_RST;
            q.sel_high <= CTRL_SEL_HIGH_RST;
            q.modf_en <= CTRL_MODF_EN_RST;
            q.div <= CTRL_DIV_RST;
            q.stat <= STAT_RST;
            q.mask <= MASK_RST;
            q.mst <= SMS_M_IDLE;
        end else begin
            q <= d;
        end
    end

    assign irq = |(q.stat & q.mask);
    assign master_serial_clock_out = q.sclk;
    assign master_serial_out = q.sh[DATA_W-1];
    assign master_out_en = q.master;
    assign slave_serial_out = q.sh[DATA_W-1];
    assign slave_serial_out_en = ~q.master & sel_act;
    assign slave_serial_out_pullup = ~(~q.master & sel_act);
endmodule

//--- sms_spi_port_assertions.sv
// concurrent checks on the serial port pins and its register bus
`timescale 1ns/1ps
module sms_chk (
    input wire logic mclk, // clock
    input wire logic reset, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic irq, // interrupt
    input wire logic master_serial_clock_out, // master clock
    input wire logic master_serial_out, // master data
    input wire logic master_out_en, // master drive
    input wire logic slave_serial_out_en, // slave drive
    input wire logic slave_serial_out_pullup // slave pullup
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_ck_idle;
        !master_out_en |-> !master_serial_clock_out;
    endproperty
    a_ck_idle: assert property (p_ck_idle)
        else $error("master clock moves while not master");
    property p_mso_hold;
        master_serial_clock_out |-> $stable(master_serial_out);
    endproperty
    a_mso_hold: assert property (p_mso_hold)
        else $error("master data changed while clock high");
    property p_pullup;
        slave_serial_out_pullup == !slave_serial_out_en;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup not opposite to slave drive");
    property p_excl;
        !(master_out_en && slave_serial_out_en);
    endproperty
    a_excl: assert property (p_excl)
        else $error("master and slave drive together");
    property p_bresp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
    property p_bblock;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bblock: assert property (p_bblock)
        else $error("write taken while response pending");
    property p_rresp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rresp: assert property (p_rresp)
        else $error("read data late");
    property p_rblock;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rblock: assert property (p_rblock)
        else $error("read taken while data pending");
    c_mck: cover property ($rose(master_serial_clock_out));
    c_sen: cover property ($rose(slave_serial_out_en));
    c_irq: cover property ($rose(irq));
endmodule
bind sms_spi_port sms_chk sms_chk_i (.mclk, .reset, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq,
    .master_serial_clock_out, .master_serial_out, .master_out_en,
    .slave_serial_out_en, .slave_serial_out_pullup);

//--- sms_peer.sv
// outside serial device: slave to the port's master, master to its slave
`timescale 1ns/1ps
module sms_peer (
    input wire logic mck, // clock from port master
    input wire logic mso, // data from port master
    output logic msi, // data to port master
    output logic sck, // clock to port slave
    output logic ssel_n, // select to port slave
    output logic sdi, // data to port slave
    input wire logic sdo, // data from port slave
    input wire logic sdo_en // port slave drives its pin
);
    logic [7:0] sh;
    logic bit_in;
    int rises;
    wire logic sdo_w = sdo_en ? sdo : 1'b1; // released pin pulls high
    assign msi = sh[7];
    initial begin
        sh = 8'h00;
        bit_in = 1'b0;
        rises = 0;
        sck = 1'b0;
        ssel_n = 1'b1;
        sdi = 1'b0;
    end
    // sample on the rise, move the next bit out on the fall
    always @(posedge mck) begin
        bit_in = mso;
        rises++;
    end
    always @(negedge mck) sh = {sh[6:0], bit_in};
    task automatic load(input logic [7:0] v);
        sh = v;
        rises = 0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        ssel_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #62.5 sck = 1'b1; // 125 ns period, far under mclk/4
            rx[i] = sdo_w;
            #62.5 sck = 1'b0;
        end
        #62.5 ssel_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule

//--- testbench.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
module testbench;
    import sms_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [AXI_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [AXI_STRB_W-1:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic master_serial_clock_out, master_serial_out, master_out_en;
    logic master_serial_in, slave_serial_clock_in, slave_serial_in;
    logic slave_serial_out, slave_serial_out_en, slave_serial_out_pullup;
    logic slave_select_in;
    logic [33:0] exp_q[$];
    logic [7:0] div, tx, rx, got;
    int bad_count = 0;
    int n_compared = 0;

    sms_spi_port sms_spi_port_i (.*);
    sms_peer sms_peer_i (.mck(master_serial_clock_out),
        .mso(master_serial_out), .msi(master_serial_in),
        .sck(slave_serial_clock_in), .ssel_n(slave_select_in),
        .sdi(slave_serial_in), .sdo(slave_serial_out),
        .sdo_en(slave_serial_out_en));

    always #2.5 mclk = ~mclk;

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic fail_wait(input string nm);
        bad_count++;
        $display("BAD %s expected answer seen none", nm);
        end_of_test();
    endtask
    // one bus transfer; w selects write, d is write data or expected read
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        logic aw, wd, ar, done;
        int n;
        exp_q.push_back({RESP_OKAY, w ? 32'h0 : d});
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        n = 0;
        do begin
            @(negedge mclk);
            aw = s_axi_awready;
            wd = s_axi_wready;
            ar = s_axi_arready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            n++;
        end while (done !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (done !== 1'b1) fail_wait("bus");
        @(posedge mclk);
    endtask
    task automatic wirq();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (irq !== 1'b1 && n < 5000);
        @(posedge mclk);
        if (irq !== 1'b1) fail_wait("irq");
    endtask

    // takes the oldest note whenever a response is handed over
    always @(posedge mclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    initial begin
        void'($urandom(32'h18399738));
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        bus(0, CTRL_OFS, {16'h0, CTRL_DIV_RST, 8'h00});
        bus(0, STAT_OFS, 32'h10);
        bus(0, MASK_OFS, 32'h0);
        bus(1, MASK_OFS, 32'h7);
        // master transfer, with a second write landing while busy
        div = 8'(2 + $urandom % 3);
        tx = 8'($urandom);
        rx = 8'($urandom);
        sms_peer_i.load(rx);
        bus(1, CTRL_OFS, {16'h0, div, 8'h01});
        bus(1, DATA_OFS, {24'h0, tx});
        bus(1, DATA_OFS, {24'h0, ~tx});
        bus(0, STAT_OFS, 32'h1a);
        bus(1, STAT_OFS, 32'h2);
        wirq();
        chk("peer byte", 34'(tx), 34'(sms_peer_i.sh));
        chk("clock rises", 34'd8, 34'(sms_peer_i.rises));
        bus(0, DATA_OFS, {24'h0, rx});
        bus(1, MASK_OFS, 32'h6);
        bus(0, STAT_OFS, 32'h11);
        chk("masked irq", 34'd0, 34'(irq));
        bus(1, MASK_OFS, 32'h7);
        bus(1, STAT_OFS, 32'h1);
        bus(0, STAT_OFS, 32'h10);
        chk("cleared irq", 34'd0, 34'(irq));
        // mode fault: select asserted while master with detection on
        bus(1, CTRL_OFS, {16'h0, div, 8'h05});
        sms_peer_i.ssel_n <= 1'b0;
        bus(0, CTRL_OFS, {16'h0, div, 8'h05});
        bus(1, DATA_OFS, 32'h5a);
        bus(0, STAT_OFS, 32'h6);
        chk("held clock", 34'd0, 34'(master_serial_clock_out));
        sms_peer_i.ssel_n <= 1'b1;
        bus(0, CTRL_OFS, {16'h0, div, 8'h05});
        bus(1, STAT_OFS, 32'h7);
        bus(0, STAT_OFS, 32'h10);
        // slave: preload, outside master swaps one byte
        tx = 8'($urandom);
        rx = 8'($urandom);
        bus(1, CTRL_OFS, {16'h0, div, 8'h00});
        chk("pullup", 34'd1, 34'(slave_serial_out_pullup));
        bus(1, DATA_OFS, {24'h0, tx});
        sms_peer_i.xfer(rx, got);
        @(posedge mclk);
        chk("slave out", 34'(tx), 34'(got));
        wirq();
        bus(0, DATA_OFS, {24'h0, rx});
        bus(0, STAT_OFS, 32'h11);
        bus(1, CTRL_OFS, {16'h0, div, 8'h02});
        bus(0, CTRL_OFS, {16'h0, div, 8'h02});
        chk("select high", 34'd1, 34'(slave_serial_out_en));
        end_of_test();
    end
endmodule
